//--- interlock_diag_pkg.sv
package interlock_diag_pkg;
  // ==========================================================
  // chain sizing and timing
  localparam int          MAX_UNITS        = 31;
  localparam int          CLK_MHZ          = 125;
  localparam longint      WARN_LIMIT_MIN   = 30;
  localparam longint      WARN_LIMIT_CYC   =
    WARN_LIMIT_MIN * 64'd60 * 64'd1000000 * CLK_MHZ;
  localparam int          RSP_PERIOD_CYC   = 64;
  localparam int          REQ_PERIOD_CYC   = 64;
  localparam int          LINK_TIMEOUT_CYC = 1024;
  localparam int          SYNC_STAGES      = 2;

  // ==========================================================
  // request byte fields
  localparam int          REQ_MAGNET       = 0;
  localparam int          REQ_ERR_RESET    = 7;
  localparam logic [7:0]  REQ_RESET_VAL    = 8'h00;

  // ==========================================================
  // response byte fields
  localparam int          RSP_OUT_ACTIVE   = 0;
  localparam int          RSP_LOCK_POSS    = 1;
  localparam int          RSP_LOCKED       = 2;
  localparam int          RSP_CHAIN_IN     = 4;
  localparam int          RSP_ACT_VALID    = 5;
  localparam int          RSP_WARN         = 6;
  localparam int          RSP_FAULT        = 7;

  // ==========================================================
  // detail byte fields, shared by warning and fault bytes
  localparam int          DET_OUT_A        = 0;
  localparam int          DET_OUT_B        = 1;
  localparam int          DET_CROSS        = 2;
  localparam int          DET_TEMP         = 3;
  localparam int          DET_ACTUATOR     = 4;
  localparam int          DET_INTERNAL     = 5;
  localparam int          DET_COMM         = 6;
  localparam int          DET_HANDLE       = 7;
  localparam logic [7:0]  WARN_MASK        = 8'h4f;
  localparam logic [7:0]  FAULT_MASK       = 8'hbf;
  localparam logic [7:0]  OUT_FAULT_MASK   = 8'h07;

  // ==========================================================
  // gateway register map, avalon byte addresses
  localparam logic [4:0]  OFS_REQUEST      = 5'h00;
  localparam logic [4:0]  OFS_RESPONSE     = 5'h04;
  localparam logic [4:0]  OFS_WARN         = 5'h08;
  localparam logic [4:0]  OFS_FAULT        = 5'h0c;
  localparam logic [4:0]  OFS_IRQ_STATUS   = 5'h10;
  localparam logic [4:0]  OFS_IRQ_MASK     = 5'h14;
  localparam int          IRQ_WARN         = 0;
  localparam int          IRQ_FAULT        = 1;
  localparam int          IRQ_LINK_LOST    = 2;
  localparam logic [2:0]  IRQ_RESET_VAL    = 3'h0;
endpackage : interlock_diag_pkg

//--- chain_diag_link_if.sv
`timescale 1ns/1ps
interface chain_diag_link_if;
  logic [7:0] req_data;
  logic       req_valid;
  logic [7:0] rsp_status;
  logic [7:0] rsp_warn;
  logic [7:0] rsp_fault;
  logic       rsp_valid;

  modport unit_end
  (
    input  req_data,
    input  req_valid,
    output rsp_status,
    output rsp_warn,
    output rsp_fault,
    output rsp_valid
  );

  modport gateway_end
  (
    output req_data,
    output req_valid,
    input  rsp_status,
    input  rsp_warn,
    input  rsp_fault,
    input  rsp_valid
  );
endinterface : chain_diag_link_if

//--- interlock_unit.sv
// Contract
// - up to 31 units share one chain
// - unit sends response data continuously
// - controller sends one request byte per unit
// - lost link keeps present switching state
// - internal error disables both safety outputs
// - fault clears: cause gone, reset fall/open
// - output faults stay latched until next release
// - warning keeps outputs on, self clears
// - warning held 30 minutes becomes fault; code never escalates the comm warning (FAULT_MASK drops it)
// - request bit0 magnet, bit7 error reset
// - response bits 0..2 outputs, lock possible, locked
// - response bits 4..7 inputs, actuator, warn, error
// - all bits active high
// - detail bytes share one flag layout
// - lock-possible bit follows turret position; code uses it only while unlocked, and door pull-over while locked
// - detail bytes available with response byte
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module interlock_unit #(
  parameter longint unsigned WARN_LIMIT_CYC =
    interlock_diag_pkg::WARN_LIMIT_CYC,
  parameter int              LINK_TIMEOUT   =
    interlock_diag_pkg::LINK_TIMEOUT_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  chain_diag_link_if.unit_end link,
  input  wire logic        i_guard_closed,
  input  wire logic        i_locked,
  input  wire logic        i_turret_rest,
  input  wire logic        i_door_pull_over,
  input  wire logic        i_actuator_present,
  input  wire logic        i_actuator_valid,
  input  wire logic        i_actuator_fault,
  input  wire logic        i_chain_in_a,
  input  wire logic        i_chain_in_b,
  input  wire logic        i_out_a_err,
  input  wire logic        i_out_b_err,
  input  wire logic        i_cross_short,
  input  wire logic        i_over_temp,
  input  wire logic        i_internal_err,
  input  wire logic        i_handle_bad,
  output logic             o_magnet,
  output logic             o_safety_out_a,
  output logic             o_safety_out_b
);

  // ==========================================================
  // pin synchronisers
  localparam int NPIN = 15;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;

  assign pin_raw = {i_guard_closed, i_locked, i_turret_rest,
                    i_door_pull_over, i_actuator_present,
                    i_actuator_valid, i_actuator_fault,
                    i_chain_in_a, i_chain_in_b, i_out_a_err,
                    i_out_b_err, i_cross_short, i_over_temp,
                    i_internal_err, i_handle_bad};

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic guard_closed, locked, turret_rest, door_pull_over;
  logic act_present, act_valid, act_fault, chain_a, chain_b;
  logic out_a_err, out_b_err, cross_short, over_temp;
  logic internal_err, handle_bad;

  assign {guard_closed, locked, turret_rest, door_pull_over,
          act_present, act_valid, act_fault, chain_a, chain_b,
          out_a_err, out_b_err, cross_short, over_temp,
          internal_err, handle_bad} = sync2_ff;

  // ==========================================================
  // link supervision and request capture
  logic [7:0]  req_ff;
  logic [31:0] idle_cnt_ff;
  logic        link_lost_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      req_ff <= interlock_diag_pkg::REQ_RESET_VAL;
    else if (link.req_valid)
      req_ff <= link.req_data;
  end

  // silence longer than the timeout flags a comm warning
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      idle_cnt_ff  <= '0;
      link_lost_ff <= 1'b0;
    end
    else if (link.req_valid)
    begin
      idle_cnt_ff  <= '0;
      link_lost_ff <= 1'b0;
    end
    else if (idle_cnt_ff == 32'(LINK_TIMEOUT - 1))
      link_lost_ff <= 1'b1;
    else
      idle_cnt_ff  <= idle_cnt_ff + 32'h1;
  end

  // only bit 0 and bit 7 carry meaning, bits 1..6 ignored
  logic rst_prev_ff;
  logic reset_fall;
  logic clear_event;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_prev_ff <= 1'b0;
    else
      rst_prev_ff <= req_ff[interlock_diag_pkg::REQ_ERR_RESET];
  end

  assign reset_fall  = rst_prev_ff &
                       !req_ff[interlock_diag_pkg::REQ_ERR_RESET];
  assign clear_event = reset_fall | !guard_closed;

  // ==========================================================
  // magnet drive
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_magnet <= 1'b0;
    else if (!link_lost_ff)
      o_magnet <= req_ff[interlock_diag_pkg::REQ_MAGNET];
  end

  // ==========================================================
  // warnings and escalation
  logic [7:0]  warn_cause;
  logic        warn_any;
  logic [63:0] warn_cnt_ff;
  logic        escalate;

  always_comb
  begin
    warn_cause = '0;
    warn_cause[interlock_diag_pkg::DET_OUT_A] = out_a_err;
    warn_cause[interlock_diag_pkg::DET_OUT_B] = out_b_err;
    warn_cause[interlock_diag_pkg::DET_CROSS] = cross_short;
    warn_cause[interlock_diag_pkg::DET_TEMP]  = over_temp;
    warn_cause[interlock_diag_pkg::DET_COMM]  = link_lost_ff;
  end

  assign warn_any = |warn_cause;

  // counter restarts whenever the warning drops, even briefly
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      warn_cnt_ff <= '0;
    else if (!warn_any)
      warn_cnt_ff <= '0;
    else if (warn_cnt_ff != WARN_LIMIT_CYC)
      warn_cnt_ff <= warn_cnt_ff + 64'h1;
  end

  assign escalate = warn_any && (warn_cnt_ff == WARN_LIMIT_CYC);

  // ==========================================================
  // fault latching
  logic [7:0] fault_cause;
  logic [7:0] fault_ff;
  logic [7:0] nxt_fault;
  logic       release_evt;
  logic       out_en_ff;

  always_comb
  begin
    fault_cause = '0;
    fault_cause[interlock_diag_pkg::DET_ACTUATOR] = act_fault;
    fault_cause[interlock_diag_pkg::DET_INTERNAL] = internal_err;
    fault_cause[interlock_diag_pkg::DET_HANDLE]   = handle_bad;
    if (escalate)
      fault_cause = fault_cause |
                    (warn_cause & interlock_diag_pkg::FAULT_MASK &
                     interlock_diag_pkg::WARN_MASK);
  end

  // output faults cannot be seen gone while outputs are off
  assign release_evt = clear_event;

  always_comb
  begin
    nxt_fault = fault_ff;
    for (int i = 0; i < 8; i++)
    begin
      if (interlock_diag_pkg::OUT_FAULT_MASK[i])
      begin
        if (release_evt)
          nxt_fault[i] = 1'b0;
      end
      else if (clear_event && !fault_cause[i])
        nxt_fault[i] = 1'b0;
    end
    nxt_fault = (nxt_fault | fault_cause) &
                interlock_diag_pkg::FAULT_MASK;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fault_ff <= '0;
    else
      fault_ff <= nxt_fault;
  end

  // ==========================================================
  // safety outputs
  logic enable;
  assign enable = guard_closed && locked && chain_a && chain_b &&
                  act_valid && (fault_ff == 8'h00) &&
                  (fault_cause == 8'h00);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_en_ff <= 1'b0;
    else
      out_en_ff <= enable;
  end

  assign o_safety_out_a = out_en_ff;
  assign o_safety_out_b = out_en_ff;

  // ==========================================================
  // response assembly and periodic transmit
  logic [7:0] status;
  logic       lock_poss;
  logic [7:0] status_ff;
  logic [7:0] warn_ff;
  logic [7:0] fault_out_ff;
  logic       rsp_valid_ff;
  logic [7:0] tx_cnt_ff;

  // locking needs rest position; unlocking blocked by door pull
  assign lock_poss = guard_closed &&
                     (locked ? !door_pull_over : turret_rest);

  always_comb
  begin
    status = '0;
    // enable is what the outputs hold from the capturing edge on
    status[interlock_diag_pkg::RSP_OUT_ACTIVE] = enable;
    status[interlock_diag_pkg::RSP_LOCK_POSS]  = lock_poss;
    status[interlock_diag_pkg::RSP_LOCKED]     =
      act_present && locked;
    status[interlock_diag_pkg::RSP_CHAIN_IN]   = chain_a && chain_b;
    status[interlock_diag_pkg::RSP_ACT_VALID]  = act_valid;
    status[interlock_diag_pkg::RSP_WARN]       = warn_any;
    status[interlock_diag_pkg::RSP_FAULT]      =
      (fault_ff != 8'h00) && !out_en_ff;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tx_cnt_ff <= '0;
    else if (tx_cnt_ff ==
             8'(interlock_diag_pkg::RSP_PERIOD_CYC - 1))
      tx_cnt_ff <= '0;
    else
      tx_cnt_ff <= tx_cnt_ff + 8'h1;
  end

  // all three bytes leave together so details match status
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status_ff    <= '0;
      warn_ff      <= '0;
      fault_out_ff <= '0;
      rsp_valid_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= (tx_cnt_ff == 8'h00);
      if (tx_cnt_ff == 8'h00)
      begin
        status_ff    <= status;
        warn_ff      <= warn_cause & interlock_diag_pkg::WARN_MASK;
        fault_out_ff <= fault_ff;
      end
    end
  end

  assign link.rsp_status = status_ff;
  assign link.rsp_warn   = warn_ff;
  assign link.rsp_fault  = fault_out_ff;
  assign link.rsp_valid  = rsp_valid_ff;

endmodule : interlock_unit

//--- diag_gateway.sv
`timescale 1ns/1ps
module diag_gateway #(
  parameter int LINK_TIMEOUT = interlock_diag_pkg::LINK_TIMEOUT_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  chain_diag_link_if.gateway_end link,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_irq
);

  // ==========================================================
  // latest unit answer
  logic [7:0] rsp_ff;
  logic [7:0] warn_ff;
  logic [7:0] fault_ff;
  logic [7:0] req_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rsp_ff   <= '0;
      warn_ff  <= '0;
      fault_ff <= '0;
    end
    else if (link.rsp_valid)
    begin
      rsp_ff   <= link.rsp_status;
      warn_ff  <= link.rsp_warn;
      fault_ff <= link.rsp_fault;
    end
  end

  // ==========================================================
  // periodic request relay
  logic [7:0]  tx_cnt_ff;
  logic        req_valid_ff;
  logic [31:0] idle_ff;
  logic        lost_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_cnt_ff    <= '0;
      req_valid_ff <= 1'b0;
    end
    else
    begin
      req_valid_ff <= (tx_cnt_ff == 8'h00);
      if (tx_cnt_ff == 8'(interlock_diag_pkg::REQ_PERIOD_CYC - 1))
        tx_cnt_ff <= '0;
      else
        tx_cnt_ff <= tx_cnt_ff + 8'h1;
    end
  end

  assign link.req_data  = req_ff;
  assign link.req_valid = req_valid_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      idle_ff <= '0;
      lost_ff <= 1'b0;
    end
    else if (link.rsp_valid)
    begin
      idle_ff <= '0;
      lost_ff <= 1'b0;
    end
    else if (idle_ff == 32'(LINK_TIMEOUT - 1))
      lost_ff <= 1'b1;
    else
      idle_ff <= idle_ff + 32'h1;
  end

  // ==========================================================
  // avalon slave, one wait state per access
  logic       wait_ff;
  logic       take;
  logic [2:0] irq_st_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] events;
  logic [7:0] rsp_prev_ff;
  logic       lost_prev_ff;

  assign take = (i_read || i_write) && !wait_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wait_ff <= 1'b1;
    else
      wait_ff <= !((i_read || i_write) && wait_ff);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_readdata <= '0;
    else if (i_read && wait_ff)
      case (i_address)
        interlock_diag_pkg::OFS_REQUEST:    o_readdata <= {24'h0, req_ff};
        interlock_diag_pkg::OFS_RESPONSE:   o_readdata <= {24'h0, rsp_ff};
        interlock_diag_pkg::OFS_WARN:       o_readdata <= {24'h0, warn_ff};
        interlock_diag_pkg::OFS_FAULT:      o_readdata <= {24'h0, fault_ff};
        interlock_diag_pkg::OFS_IRQ_STATUS: o_readdata <= {29'h0, irq_st_ff};
        interlock_diag_pkg::OFS_IRQ_MASK:   o_readdata <= {29'h0, irq_mask_ff};
        default:                            o_readdata <= '0;
      endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      req_ff <= interlock_diag_pkg::REQ_RESET_VAL;
    else if (take && i_write &&
             i_address == interlock_diag_pkg::OFS_REQUEST)
      req_ff <= i_writedata[7:0];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_mask_ff <= interlock_diag_pkg::IRQ_RESET_VAL;
    else if (take && i_write &&
             i_address == interlock_diag_pkg::OFS_IRQ_MASK)
      irq_mask_ff <= i_writedata[2:0];
  end

  // ==========================================================
  // interrupt events: rising warn, rising fault, link lost
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rsp_prev_ff  <= '0;
      lost_prev_ff <= 1'b0;
    end
    else
    begin
      rsp_prev_ff  <= rsp_ff;
      lost_prev_ff <= lost_ff;
    end
  end

  always_comb
  begin
    events = '0;
    events[interlock_diag_pkg::IRQ_WARN]      =
      rsp_ff[interlock_diag_pkg::RSP_WARN] &
      !rsp_prev_ff[interlock_diag_pkg::RSP_WARN];
    events[interlock_diag_pkg::IRQ_FAULT]     =
      rsp_ff[interlock_diag_pkg::RSP_FAULT] &
      !rsp_prev_ff[interlock_diag_pkg::RSP_FAULT];
    events[interlock_diag_pkg::IRQ_LINK_LOST] = lost_ff & !lost_prev_ff;
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_st_ff <= interlock_diag_pkg::IRQ_RESET_VAL;
    else if (take && i_write &&
             i_address == interlock_diag_pkg::OFS_IRQ_STATUS)
      irq_st_ff <= (irq_st_ff & ~i_writedata[2:0]) | events;
    else
      irq_st_ff <= irq_st_ff | events;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_st_ff & irq_mask_ff);
  end

  assign o_waitrequest = wait_ff;

endmodule : diag_gateway

//--- interlock_diag_props.sv
`timescale 1ns/1ps
module interlock_diag_props (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] req_data,
  input wire logic       req_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [7:0] rsp_warn,
  input wire logic [7:0] rsp_fault,
  input wire logic       rsp_valid
);
  // ==========================================
  // link checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_RSP_PERIOD: assert property (rsp_valid |-> ##64 rsp_valid)
    else $error("response pulse period wrong");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid [*8])
    else $error("response pulse too long");
  AST_REQ_PERIOD: assert property (req_valid |-> ##64 req_valid)
    else $error("request pulse period wrong");
  AST_SPARE_ZERO: assert property (!rsp_status[3] &&
    (rsp_warn & ~interlock_diag_pkg::WARN_MASK) == 8'h00 &&
    (rsp_fault & ~interlock_diag_pkg::FAULT_MASK) == 8'h00)
    else $error("unassigned bit set");
  AST_FAULT_OFF: assert property (rsp_status[7] |-> !rsp_status[0])
    else $error("fault with outputs on");
  AST_FAULT_DETAIL: assert property (rsp_status[7] |-> rsp_fault != 8'h00)
    else $error("fault byte empty");
  AST_WARN_DETAIL: assert property (rsp_status[6] == (rsp_warn != 8'h00))
    else $error("warning byte mismatch");
  AST_OUT_COND: assert property (rsp_status[0] |->
    rsp_status[4] && rsp_status[5])
    else $error("outputs on without inputs");
  // data byte is only relayed, never judged here
  COV_FAULT: cover property (rsp_status[7]);
  COV_WARN: cover property (rsp_status[6]);
  COV_ON: cover property (rsp_status[0] && req_data[0]);
endmodule : interlock_diag_props

//--- test_interlock_serial_diag_bytes.sv
`timescale 1ns/1ps
module test_interlock_serial_diag_bytes;
  // ==========================================
  // bench signals
  localparam int          WARN_CYC = 2000;
  localparam logic [14:0] OK       = 15'h01b7;
  logic        i_ref_clk;
  logic        i_rst_n;
  logic [4:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic [31:0] rd;
  logic        o_waitrequest;
  logic        o_irq;
  logic        o_magnet;
  logic        o_safety_out_a;
  logic        o_safety_out_b;
  logic [14:0] pin;
  logic [7:0]  req;
  int          fail_count;
  int          checks_done;
  int          seed;
  int          fp[3];
  int          fb[3];

  chain_diag_link_if chain_diag_link_if_i ();
  interlock_unit #(.WARN_LIMIT_CYC(WARN_CYC), .LINK_TIMEOUT(200))
    interlock_unit_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(chain_diag_link_if_i.unit_end), .i_guard_closed(pin[0]),
    .i_locked(pin[1]), .i_turret_rest(pin[2]),
    .i_door_pull_over(pin[3]), .i_actuator_present(pin[4]),
    .i_actuator_valid(pin[5]), .i_actuator_fault(pin[6]),
    .i_chain_in_a(pin[7]), .i_chain_in_b(pin[8]),
    .i_out_a_err(pin[9]), .i_out_b_err(pin[10]),
    .i_cross_short(pin[11]), .i_over_temp(pin[12]),
    .i_internal_err(pin[13]), .i_handle_bad(pin[14]),
    .o_magnet(o_magnet), .o_safety_out_a(o_safety_out_a),
    .o_safety_out_b(o_safety_out_b));
  diag_gateway #(.LINK_TIMEOUT(200)) diag_gateway_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(chain_diag_link_if_i.gateway_end), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_irq(o_irq));
  interlock_diag_props interlock_diag_props_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .req_data(chain_diag_link_if_i.req_data),
    .req_valid(chain_diag_link_if_i.req_valid),
    .rsp_status(chain_diag_link_if_i.rsp_status),
    .rsp_warn(chain_diag_link_if_i.rsp_warn),
    .rsp_fault(chain_diag_link_if_i.rsp_fault),
    .rsp_valid(chain_diag_link_if_i.rsp_valid));

  // ==========================================
  // tasks
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    n = 0;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end
    while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    check("wait cycles", 32'h2, 32'(n));
  endtask : av

  task rdc(input logic [4:0] a, input logic [31:0] e, input string what);
    av(1'b0, a, 32'h0);
    check(what, e, rd);
  endtask : rdc

  // long enough for two link periods plus synchronisers
  task settle();
    repeat (160) @(posedge i_ref_clk);
  endtask : settle

  function automatic logic [7:0] exp_status(input logic [14:0] p,
                                            input logic w);
    logic on;
    on = p[0] & p[1] & p[7] & p[8] & p[5];
    exp_status = {1'b0, w, p[5], p[7] & p[8], 1'b0, p[4] & p[1],
                  p[0] & (p[1] ? !p[3] : p[2]), on};
  endfunction : exp_status

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ==========================================
  // clock, reset, watchdog
  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    repeat (40000) @(posedge i_ref_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    {i_rst_n, i_read, i_write, i_address, i_writedata, pin} = '0;
    {fail_count, checks_done} = '0;
    seed = 70298;
    fp = '{13, 6, 14};
    fb = '{5, 4, 7};
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rdc(interlock_diag_pkg::OFS_REQUEST, 32'h0, "request");
    rdc(5'h18, 32'h0, "unmapped");
    av(1'b1, interlock_diag_pkg::OFS_RESPONSE, 32'hff);
    rdc(interlock_diag_pkg::OFS_RESPONSE, 32'h0, "response ro");
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      pin <= (i < 2) ? OK : OK ^ (15'($random(seed)) & 15'h01bf);
      req = 8'($random(seed)) & 8'h7f;
      av(1'b1, interlock_diag_pkg::OFS_REQUEST, {24'h0, req});
      settle();
      check("magnet", {31'h0, req[0]}, {31'h0, o_magnet});
      check("out", 32'(exp_status(pin, 1'b0) & 8'h01), {31'h0, o_safety_out_a});
      rdc(interlock_diag_pkg::OFS_RESPONSE, {24'h0, exp_status(pin, 1'b0)}, "rsp");
    end
    $display("request test done");
    pin <= OK;
    av(1'b1, interlock_diag_pkg::OFS_IRQ_MASK, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      pin <= OK | (15'h1 << (9 + k));
      settle();
      rdc(interlock_diag_pkg::OFS_WARN, 32'h1 << k, "warn");
      rdc(interlock_diag_pkg::OFS_RESPONSE, {24'h0, exp_status(OK, 1'b1)}, "rsp");
      check("irq", 32'h1, {31'h0, o_irq});
      pin <= OK;
      settle();
      rdc(interlock_diag_pkg::OFS_WARN, 32'h0, "warn gone");
    end
    rdc(interlock_diag_pkg::OFS_IRQ_STATUS, 32'h1, "irq status");
    av(1'b1, interlock_diag_pkg::OFS_IRQ_STATUS, 32'h7);
    rdc(interlock_diag_pkg::OFS_IRQ_STATUS, 32'h0, "irq clear");
    check("irq low", 32'h0, {31'h0, o_irq});
    av(1'b1, interlock_diag_pkg::OFS_IRQ_MASK, 32'h0);
    $display("warning test done");
    pin <= OK | 15'h1000;
    repeat (WARN_CYC + 300) @(posedge i_ref_clk);
    rdc(interlock_diag_pkg::OFS_FAULT, 32'h8, "escalated");
    check("out off", 32'h0, {31'h0, o_safety_out_b});
    rdc(interlock_diag_pkg::OFS_IRQ_STATUS, 32'h3, "irq fault");
    pin <= OK;
    settle();
    rdc(interlock_diag_pkg::OFS_FAULT, 32'h8, "still latched");
    av(1'b1, interlock_diag_pkg::OFS_REQUEST, 32'h80);
    settle();
    av(1'b1, interlock_diag_pkg::OFS_REQUEST, 32'h0);
    settle();
    rdc(interlock_diag_pkg::OFS_FAULT, 32'h0, "reset by bit");
    check("out back", 32'h1, {31'h0, o_safety_out_a});
    $display("escalation test done");
    for (int k = 0; k < 3; k++)
    begin
      pin <= OK | (15'h1 << fp[k]);
      settle();
      rdc(interlock_diag_pkg::OFS_FAULT, 32'h1 << fb[k], "fault");
      check("fault off", 32'h0, {31'h0, o_safety_out_a});
      pin <= OK;
      settle();
      rdc(interlock_diag_pkg::OFS_FAULT, 32'h1 << fb[k], "held");
      pin <= OK & 15'h7ffe;
      settle();
      pin <= OK;
      settle();
      rdc(interlock_diag_pkg::OFS_FAULT, 32'h0, "reset by guard");
    end
    $display("fault test done");
    av(1'b1, interlock_diag_pkg::OFS_REQUEST, 32'h1);
    settle();
    check("magnet on", 32'h1, {31'h0, o_magnet});
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check("in reset", 32'h8, {28'h0, o_waitrequest, o_irq, o_magnet, o_safety_out_a});
    i_rst_n <= 1'b1;
    rdc(interlock_diag_pkg::OFS_REQUEST, 32'h0, "request reset");
    settle();
    check("magnet reset", 32'h0, {31'h0, o_magnet});
    check("out reset", 32'h1, {31'h0, o_safety_out_b});
    $display("reset test done");
    summarize();
  end
endmodule : test_interlock_serial_diag_bytes
